// ===== aubt_params.svh
// Purpose: Constants for the address unit and block transfer logic.
// Assumes: Included by the ALU, the core and the bench; the package, FIFO and memory model do not include it.
// Notes:   Opcodes are the seven-bit octal codes written in hex.
`ifndef AUBT_PARAMS_SVH
`define AUBT_PARAMS_SVH
`define AUBT_OP_ADD     7'h18
`define AUBT_OP_SUB     7'h19
`define AUBT_OP_MUL     7'h1a
`define AUBT_OP_CHAN    7'h1b
`define AUBT_OP_BRD     7'h1c
`define AUBT_OP_BST     7'h1d
`define AUBT_OP_TRD     7'h1e
`define AUBT_OP_TST     7'h1f
`define AUBT_OP_SLONG   7'h20
`define AUBT_LAST_IDX   6'h3f
`define AUBT_FIFO_DEPTH 16
`define AUBT_FIFO_W     88
`endif

// ===== aubt_pkg.sv
// Purpose: Types shared by the address unit and block transfer logic.
// Assumes: Nothing.
// Notes:   Constants live in aubt_params.svh.
package aubt_pkg;
  typedef logic [23:0] aubt_addr_t;
  typedef logic [63:0] aubt_word_t;
  typedef logic [5:0]  aubt_idx_t;
  typedef enum logic [2:0] {ST_IDLE, ST_CHAN, ST_RD, ST_WR, ST_DRAIN} aubt_state_t;
endpackage

// ===== aubt_alu.sv
// Purpose: Address add, subtract and multiply with zero-designator cases.
// Assumes: Operands are the address registers selected by j and k.
// Notes:   Purely combinational; no overflow is reported.
`timescale 1ns/1ns
`default_nettype none
`include "aubt_params.svh"
module aubt_alu
  import aubt_pkg::*;
(
  input  wire logic [6:0]         i_op,
  input  wire logic [2:0]         i_j,
  input  wire logic [2:0]         i_k,
  input  wire aubt_pkg::aubt_addr_t i_aj,
  input  wire aubt_pkg::aubt_addr_t i_ak,
  output aubt_pkg::aubt_addr_t    o_res
);
  logic [47:0] prod;
  logic        jz;
  logic        kz;

  always_comb
  begin
    prod  = 48'(i_aj) * 48'(i_ak);
    jz    = (i_j == 3'h0);
    kz    = (i_k == 3'h0);
    o_res = 24'h000000;
    case (i_op)
      `AUBT_OP_ADD:
      begin
        if (jz && kz)
          o_res = 24'h000001;
        else if (jz)
          o_res = i_ak;
        else if (kz)
          o_res = i_aj + 24'h000001;
        else
          o_res = i_aj + i_ak;
      end
      `AUBT_OP_SUB:
      begin
        if (jz && kz)
          o_res = 24'hffffff;
        else if (jz)
          o_res = 24'h000000 - i_ak;
        else if (kz)
          o_res = i_aj - 24'h000001;
        else
          o_res = i_aj - i_ak;
      end
      `AUBT_OP_MUL:
      begin
        if (jz)
          o_res = 24'h000000;
        else if (kz)
          o_res = i_aj;
        else
          o_res = prod[23:0];
      end
      default:
        o_res = 24'h000000;
    endcase
  end
endmodule
`default_nettype wire

// ===== aubt_fifo.sv
// Purpose: Store-path FIFO between register reads and memory writes.
// Assumes: Same clock on both sides.
// Notes:   Full and empty are exact; the drain side may stall.
`timescale 1ns/1ns
`default_nettype none
module aubt_fifo #(
  parameter int W = 88,
  parameter int D = 16
) (
  input  wire logic         i_mclk,
  input  wire logic         i_rst_b,
  input  wire logic         i_ce,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign o_in_ready  = (cnt_q != (AW+1)'(D));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data  = mem_q[rp_q];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_ff @(posedge i_mclk)
  begin
    if (i_ce && push)
      mem_q[wp_q] <= i_in_data;
  end

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else if (i_ce)
    begin
      if (push)
        wp_q <= wp_q + AW'(1);
      if (pop)
        rp_q <= rp_q + AW'(1);
      if (push && !pop)
        cnt_q <= cnt_q + (AW+1)'(1);
      else if (pop && !push)
        cnt_q <= cnt_q - (AW+1)'(1);
    end
  end
endmodule
`default_nettype wire

// ===== aubt_core.sv
// Purpose: Executes address arithmetic, channel status, block transfers
//          and the long scalar constant load.
// Assumes: Memory and channel status logic run on i_mclk.
// Notes:   One instruction at a time; o_inst_ready shows acceptance.
`timescale 1ns/1ns
`default_nettype none
`include "aubt_params.svh"
module aubt_core
  import aubt_pkg::*;
(
  input  wire logic                 i_mclk,
  input  wire logic                 i_rst_b,
  input  wire logic                 i_ce,
  input  wire logic                 i_inst_valid,
  input  wire logic [15:0]          i_inst_word,
  input  wire logic [15:0]          i_inst_ext,
  output logic                      o_inst_ready,
  output logic                      o_done,
  input  wire logic                 i_ld_en,
  input  wire logic                 i_ld_scalar,
  input  wire logic [2:0]           i_ld_idx,
  input  wire aubt_pkg::aubt_word_t i_ld_data,
  output logic                      o_mem_req,
  output logic                      o_mem_we,
  output aubt_pkg::aubt_addr_t      o_mem_addr,
  output aubt_pkg::aubt_word_t      o_mem_wdata,
  input  wire logic                 i_mem_ack,
  input  wire aubt_pkg::aubt_word_t i_mem_rdata,
  input  wire logic [5:0]           i_irq_chan,
  output logic [5:0]                o_chan_sel,
  input  wire aubt_pkg::aubt_addr_t i_chan_cur_addr,
  input  wire logic                 i_chan_err,
  output logic                      o_chan_err_clr,
  output logic                      o_wb_valid,
  output logic [1:0]                o_wb_file,
  output aubt_pkg::aubt_idx_t       o_wb_idx,
  output aubt_pkg::aubt_word_t      o_wb_data
);
  import aubt_pkg::*;

  // ****************************************************************
  // Decode and register files
  // ****************************************************************
  aubt_state_t st_q;
  aubt_addr_t  a_q [8];
  aubt_word_t  s_q [8];
  aubt_addr_t  b_q [64];
  aubt_word_t  t_q [64];
  logic [6:0]  op;
  logic [2:0]  di;
  logic [2:0]  dj;
  logic [2:0]  dk;
  logic [21:0] long_k;
  logic        accept;
  aubt_addr_t  alu_res;
  aubt_idx_t   idx_q;
  aubt_addr_t  addr_q;
  logic [6:0]  left_q;
  logic [2:0]  xi_q;
  logic [2:0]  xk_q;
  logic        is_t_q;
  logic        rd_ack;
  logic        push;
  logic        f_in_ready;
  logic        f_out_valid;
  logic [87:0] f_out_data;
  logic        a_we;
  logic [2:0]  a_wi;
  aubt_addr_t  a_wd;
  logic        s_we;
  logic [2:0]  s_wi;
  aubt_word_t  s_wd;
  logic        fin;

  function automatic aubt_idx_t next_idx(input aubt_idx_t v);
    next_idx = (v == `AUBT_LAST_IDX) ? 6'h00 : v + 6'h01;
  endfunction

  assign op     = i_inst_word[15:9];
  assign di     = i_inst_word[8:6];
  assign dj     = i_inst_word[5:3];
  assign dk     = i_inst_word[2:0];
  assign long_k = {dj, dk, i_inst_ext};
  assign accept = i_inst_valid && (st_q == ST_IDLE);
  assign rd_ack = i_mem_ack && o_mem_req && !o_mem_we;
  assign push   = (st_q == ST_WR) && f_in_ready;

  aubt_alu u_alu (
    .i_op  (op),
    .i_j   (dj),
    .i_k   (dk),
    .i_aj  (a_q[dj]),
    .i_ak  (a_q[dk]),
    .o_res (alu_res)
  );

  aubt_fifo #(
    .W (`AUBT_FIFO_W),
    .D (`AUBT_FIFO_DEPTH)
  ) u_fifo (
    .i_mclk      (i_mclk),
    .i_rst_b     (i_rst_b),
    .i_ce        (i_ce),
    .i_in_valid  (st_q == ST_WR),
    .o_in_ready  (f_in_ready),
    .i_in_data   ({addr_q, is_t_q ? t_q[idx_q] : {40'h0, b_q[idx_q]}}),
    .o_out_valid (f_out_valid),
    .i_out_ready (!o_mem_req),
    .o_out_data  (f_out_data)
  );

  // Selects the address register write of this cycle.
  always_comb
  begin
    a_we = 1'b0;
    a_wi = di;
    a_wd = alu_res;
    if (accept)
    begin
      case (op)
        `AUBT_OP_ADD, `AUBT_OP_SUB, `AUBT_OP_MUL:
          a_we = 1'b1;
        `AUBT_OP_CHAN:
        begin
          a_we = (dj == 3'h0);
          a_wd = {18'h0, i_irq_chan};
        end
        default:
          a_we = 1'b0;
      endcase
    end
    else if (st_q == ST_CHAN)
    begin
      a_we = 1'b1;
      a_wi = xi_q;
      if (xk_q == 3'h0)
        a_wd = i_chan_cur_addr;
      else if (xk_q == 3'h1)
        a_wd = {23'h0, i_chan_err};
      else
        a_wd = 24'h000000;
    end
    else if (i_ld_en && !i_ld_scalar && st_q == ST_IDLE)
    begin
      a_we = 1'b1;
      a_wi = i_ld_idx;
      a_wd = i_ld_data[23:0];
    end
  end

  always_comb
  begin
    s_we = 1'b0;
    s_wi = di;
    s_wd = {42'h0, long_k};
    if (accept)
      s_we = (op == `AUBT_OP_SLONG);
    else if (i_ld_en && i_ld_scalar && st_q == ST_IDLE)
    begin
      s_we = 1'b1;
      s_wi = i_ld_idx;
      s_wd = i_ld_data;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_ce && a_we)
      a_q[a_wi] <= a_wd;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_ce && s_we)
      s_q[s_wi] <= s_wd;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_ce && rd_ack && !is_t_q)
      b_q[idx_q] <= i_mem_rdata[23:0];
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_ce && rd_ack && is_t_q)
      t_q[idx_q] <= i_mem_rdata;
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb
  begin
    fin = 1'b0;
    case (st_q)
      ST_IDLE:
        fin = accept && !((op == `AUBT_OP_CHAN) && (dj != 3'h0))
              && !((op >= `AUBT_OP_BRD) && (op <= `AUBT_OP_TST));
      ST_CHAN:
        fin = 1'b1;
      ST_RD:
        fin = rd_ack && (left_q == 7'h01);
      ST_DRAIN:
        fin = !f_out_valid && !o_mem_req;
      default:
        fin = 1'b0;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      st_q   <= ST_IDLE;
      idx_q  <= 6'h00;
      addr_q <= 24'h000000;
      left_q <= 7'h00;
      xi_q   <= 3'h0;
      xk_q   <= 3'h0;
      is_t_q <= 1'b0;
    end
    else if (i_ce)
    begin
      case (st_q)
        ST_IDLE:
        begin
          xi_q   <= di;
          xk_q   <= dk;
          is_t_q <= op[1];
          idx_q  <= a_q[di][5:0];
          addr_q <= a_q[0];
          left_q <= {1'b0, dj, dk} + 7'h01;
          if (accept && op == `AUBT_OP_CHAN && dj != 3'h0)
            st_q <= ST_CHAN;
          else if (accept && (op == `AUBT_OP_BRD || op == `AUBT_OP_TRD))
            st_q <= ST_RD;
          else if (accept && (op == `AUBT_OP_BST || op == `AUBT_OP_TST))
            st_q <= ST_WR;
        end
        ST_CHAN:
          st_q <= ST_IDLE;
        ST_RD:
        begin
          if (rd_ack)
          begin
            idx_q  <= next_idx(idx_q);
            addr_q <= addr_q + 24'h000001;
            left_q <= left_q - 7'h01;
            if (fin)
              st_q <= ST_IDLE;
          end
        end
        ST_WR:
        begin
          if (push)
          begin
            idx_q  <= next_idx(idx_q);
            addr_q <= addr_q + 24'h000001;
            left_q <= left_q - 7'h01;
            if (left_q == 7'h01)
              st_q <= ST_DRAIN;
          end
        end
        ST_DRAIN:
        begin
          if (fin)
            st_q <= ST_IDLE;
        end
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Memory port, one word per request
  // ****************************************************************
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_mem_req   <= 1'b0;
      o_mem_we    <= 1'b0;
      o_mem_addr  <= 24'h000000;
      o_mem_wdata <= 64'h0000000000000000;
    end
    else if (i_ce)
    begin
      if (o_mem_req)
      begin
        if (i_mem_ack)
          o_mem_req <= 1'b0;
      end
      else if (f_out_valid)
      begin
        o_mem_req   <= 1'b1;
        o_mem_we    <= 1'b1;
        o_mem_addr  <= f_out_data[87:64];
        o_mem_wdata <= f_out_data[63:0];
      end
      else if (st_q == ST_RD)
      begin
        o_mem_req  <= 1'b1;
        o_mem_we   <= 1'b0;
        o_mem_addr <= addr_q;
      end
    end
  end

  // ****************************************************************
  // Status, channel and write-back outputs
  // ****************************************************************
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_inst_ready   <= 1'b0;
      o_done         <= 1'b0;
      o_chan_sel     <= 6'h00;
      o_chan_err_clr <= 1'b0;
    end
    else if (i_ce)
    begin
      o_inst_ready   <= (st_q == ST_IDLE) && !accept || fin;
      o_done         <= fin;
      o_chan_err_clr <= (st_q == ST_CHAN) && (xk_q == 3'h1);
      if (accept)
        o_chan_sel <= a_q[dj][5:0];
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_wb_valid <= 1'b0;
      o_wb_file  <= 2'h0;
      o_wb_idx   <= 6'h00;
      o_wb_data  <= 64'h0000000000000000;
    end
    else if (i_ce)
    begin
      o_wb_valid <= a_we || s_we || rd_ack;
      if (rd_ack)
      begin
        o_wb_file <= is_t_q ? 2'h3 : 2'h2;
        o_wb_idx  <= idx_q;
        o_wb_data <= is_t_q ? i_mem_rdata : {40'h0, i_mem_rdata[23:0]};
      end
      else if (s_we)
      begin
        o_wb_file <= 2'h1;
        o_wb_idx  <= {3'h0, s_wi};
        o_wb_data <= s_wd;
      end
      else
      begin
        o_wb_file <= 2'h0;
        o_wb_idx  <= {3'h0, a_wi};
        o_wb_data <= {40'h0, a_wd};
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  aubt_addr_t chk_sum;
  logic [6:0] chk_len_q;
  logic [6:0] chk_cnt_q;

  assign chk_sum = a_q[dj] + a_q[dk];

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      chk_len_q <= 7'h00;
      chk_cnt_q <= 7'h00;
    end
    else if (i_ce)
    begin
      if (accept)
      begin
        chk_len_q <= {1'b0, dj, dk} + 7'h01;
        chk_cnt_q <= 7'h00;
      end
      else if (rd_ack || push)
        chk_cnt_q <= chk_cnt_q + 7'h01;
    end
  end

  default clocking cb @(posedge i_mclk iff i_ce);
  endclocking
  default disable iff (!i_rst_b);

  a_add_sum: assert property (accept && op == `AUBT_OP_ADD && dj != 3'h0 && dk != 3'h0
    |=> o_wb_valid && o_wb_data == {40'h0, $past(chk_sum)})
    else $error("add result wrong");
  a_add_zero_des: assert property (accept && op == `AUBT_OP_ADD && dj == 3'h0 && dk == 3'h0
    |=> o_wb_data == 64'h1)
    else $error("add with zero designators wrong");
  a_sub_both_zero: assert property (accept && op == `AUBT_OP_SUB && dj == 3'h0 && dk == 3'h0
    |=> o_wb_data == 64'hffffff)
    else $error("subtract minus one wrong");
  a_mul_clear: assert property (accept && op == `AUBT_OP_MUL && dj == 3'h0
    |=> o_wb_valid && o_wb_data == 64'h0)
    else $error("multiply clear wrong");
  a_err_flag_clr: assert property (st_q == ST_CHAN && xk_q == 3'h1
    |=> o_chan_err_clr && o_wb_data[63:1] == 63'h0 ##1 !o_chan_err_clr)
    else $error("error flag read wrong");
  a_long_const: assert property (accept && op == `AUBT_OP_SLONG
    |=> o_wb_file == 2'h1 && o_wb_data == {42'h0, $past(long_k)})
    else $error("long constant load wrong");
  a_word_count: assert property ((st_q == ST_RD || st_q == ST_DRAIN) && fin
    |-> chk_cnt_q + (st_q == ST_RD ? 7'h01 : 7'h00) == chk_len_q)
    else $error("transfer word count wrong");
  a_index_wrap: assert property ((rd_ack || push) && idx_q == `AUBT_LAST_IDX
    |=> idx_q == 6'h00)
    else $error("register index did not wrap");
  a_addr_step: assert property (rd_ack && left_q != 7'h01
    |=> addr_q == $past(o_mem_addr) + 24'h000001 ##1 o_mem_req && o_mem_addr == addr_q)
    else $error("read address did not step by one");

  c_add: cover property (accept && op == `AUBT_OP_ADD);
  c_b_read: cover property (st_q == ST_RD && fin && !is_t_q);
  c_t_store: cover property (st_q == ST_DRAIN && fin && is_t_q);
  c_wrap: cover property (push && idx_q == `AUBT_LAST_IDX);
endmodule
`default_nettype wire

// ===== aubt_mem_model.sv
// Purpose: Memory and channel status partner for aubt_core.
// Assumes: Runs on the core clock; memory holds 256 words.
// Notes:   Read data toggles outside an answer so stale data never looks valid.
`timescale 1ns/1ns
`default_nettype none
module aubt_mem_model (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_b,
  input  wire logic [2:0]  i_lat,
  input  wire logic        i_req,
  input  wire logic        i_we,
  input  wire logic [23:0] i_addr,
  input  wire logic [63:0] i_wdata,
  output logic             o_ack,
  output logic [63:0]      o_rdata,
  input  wire logic [5:0]  i_sel,
  output logic [23:0]      o_cur_addr,
  output logic             o_err,
  input  wire logic        i_err_clr,
  input  wire logic        i_err_set
);
  logic [63:0] mem [0:255];
  logic [2:0]  wait_q;
  logic [63:0] err_q;
  int          wr_cnt;
  initial
    for (int a = 0; a < 256; a++) mem[a] = {8'h5a, 24'(a * 3), 8'hc3, 24'(a * 7 + 1)};
  // Each request is answered once, after i_lat waiting cycles.
  always @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_ack   <= 1'b0;
      wait_q  <= 3'h0;
      o_rdata <= 64'h0;
      wr_cnt  <= 0;
    end
    else if (i_req && !o_ack && wait_q >= i_lat)
    begin
      o_ack   <= 1'b1;
      wait_q  <= 3'h0;
      o_rdata <= mem[i_addr[7:0]];
      if (i_we)
      begin
        mem[i_addr[7:0]] <= i_wdata;
        wr_cnt           <= wr_cnt + 1;
      end
    end
    else
    begin
      o_ack   <= 1'b0;
      wait_q  <= i_req ? wait_q + 3'h1 : 3'h0;
      o_rdata <= ~o_rdata;
    end
  end
  assign o_cur_addr = 24'h100000 | {18'h0, i_sel};
  assign o_err      = err_q[i_sel];
  always @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      err_q <= 64'h0;
    else if (i_err_set)
      err_q <= 64'hffffffffffffffff;
    else if (i_err_clr)
      err_q[i_sel] <= 1'b0;
  end
endmodule
`default_nettype wire

// ===== address_unit_block_transfer_exec_tb_top.sv
// Purpose: Self-checking bench for aubt_core.
// Assumes: aubt_mem_model answers memory and channel status.
// Notes:   A monitor queues every register write-back for the tests.
`timescale 1ns/1ns
`default_nettype none
`include "aubt_params.svh"
module address_unit_block_transfer_exec_tb_top;
  import aubt_pkg::*;
  logic        mclk, rst_b, inst_valid, inst_ready, done, ld_en, ld_scalar;
  logic        mem_req, mem_we, mem_ack, chan_err, err_clr, err_set, wb_valid;
  logic [15:0] inst_word, inst_ext;
  logic [2:0]  ld_idx, lat;
  logic [5:0]  irq_chan, chan_sel, wb_idx;
  logic [1:0]  wb_file;
  aubt_word_t  ld_data, mem_wdata, mem_rdata, wb_data;
  aubt_addr_t  mem_addr, cur_addr;
  logic [71:0] wbq [$];
  int          miscompares, checks_done, done_cnt;
  aubt_core u_aubt_core (.i_mclk(mclk), .i_rst_b(rst_b), .i_ce(1'b1), .i_inst_valid(inst_valid),
    .i_inst_word(inst_word), .i_inst_ext(inst_ext), .o_inst_ready(inst_ready), .o_done(done),
    .i_ld_en(ld_en), .i_ld_scalar(ld_scalar), .i_ld_idx(ld_idx), .i_ld_data(ld_data),
    .o_mem_req(mem_req), .o_mem_we(mem_we), .o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata),
    .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata), .i_irq_chan(irq_chan), .o_chan_sel(chan_sel),
    .i_chan_cur_addr(cur_addr), .i_chan_err(chan_err), .o_chan_err_clr(err_clr),
    .o_wb_valid(wb_valid), .o_wb_file(wb_file), .o_wb_idx(wb_idx), .o_wb_data(wb_data));
  aubt_mem_model u_aubt_mem_model (.i_mclk(mclk), .i_rst_b(rst_b), .i_lat(lat), .i_req(mem_req),
    .i_we(mem_we), .i_addr(mem_addr), .i_wdata(mem_wdata), .o_ack(mem_ack), .o_rdata(mem_rdata),
    .i_sel(chan_sel), .o_cur_addr(cur_addr), .o_err(chan_err), .i_err_clr(err_clr),
    .i_err_set(err_set));
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    if (wb_valid === 1'b1) wbq.push_back({wb_file, wb_idx, wb_data});
    if (done === 1'b1) done_cnt++;
  end
  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  function automatic aubt_word_t pat(input int a);
    return {8'h5a, 24'(a * 3), 8'hc3, 24'(a * 7 + 1)};
  endfunction
  task automatic conclude();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [71:0] seen, input logic [71:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic chk_wb(input logic [71:0] e);
    if (wbq.size() == 0) check(72'hx, e);
    else check(wbq.pop_front(), e);
  endtask
  task automatic ld(input logic sc, input logic [2:0] idx, input aubt_word_t d);
    @(posedge mclk);
    ld_en     <= 1'b1;
    ld_scalar <= sc;
    ld_idx    <= idx;
    ld_data   <= d;
    @(posedge mclk);
    ld_en <= 1'b0;
    // Lets the preload write-back reach the queue before the caller clears it.
    repeat (2) @(negedge mclk);
  endtask
  // Holds the instruction until taken, then waits for the done pulse.
  task automatic exec(input logic [15:0] w, input logic [15:0] x);
    int n;
    int t;
    n = done_cnt;
    @(posedge mclk);
    inst_valid <= 1'b1;
    inst_word  <= w;
    inst_ext   <= x;
    for (t = 0; t < 4000; t++)
    begin
      @(negedge mclk);
      if (inst_ready === 1'b1) break;
    end
    @(posedge mclk);
    inst_valid <= 1'b0;
    for (t = t; t < 4000 && done_cnt == n; t++) @(negedge mclk);
    if (t >= 4000)
    begin
      miscompares++;
      conclude();
    end
  endtask
  // ****************************************************************
  // Tests.
  // ****************************************************************
  task automatic t_arith();
    logic [31:0] tab [12] = '{32'h13000005, 32'h03000007, 32'h00000001, 32'h10ffffff,
      32'h5a000009, 32'h43fffff9, 32'h40ffffff, 32'h58000006,
      32'h93fffff2, 32'h83000000, 32'ha8123456, 32'h9b000031};
    ld(1'b0, 3'h2, 64'hfffffe);
    ld(1'b0, 3'h3, 64'h7);
    ld(1'b0, 3'h5, 64'h123456);
    foreach (tab[n])
    begin
      wbq.delete();
      exec({`AUBT_OP_ADD + 7'(tab[n][31:30]), 3'h1, tab[n][29:24]}, 16'h0);
      chk_wb({8'h01, 40'h0, tab[n][23:0]});
    end
    $display("arithmetic test done");
  endtask
  task automatic t_chan();
    wbq.delete();
    exec({`AUBT_OP_CHAN, 3'h1, 6'h00}, 16'h0);
    chk_wb({8'h01, 64'h2d});
    exec({`AUBT_OP_CHAN, 3'h1, 6'h28}, 16'h0);
    chk_wb({8'h01, 64'h100016});
    @(posedge mclk);
    err_set <= 1'b1;
    @(posedge mclk);
    err_set <= 1'b0;
    exec({`AUBT_OP_CHAN, 3'h1, 6'h2a}, 16'h0);
    chk_wb({8'h01, 64'h0});
    exec({`AUBT_OP_CHAN, 3'h1, 6'h29}, 16'h0);
    chk_wb({8'h01, 64'h1});
    exec({`AUBT_OP_CHAN, 3'h1, 6'h29}, 16'h0);
    chk_wb({8'h01, 64'h0});
    $display("channel test done");
  endtask
  task automatic t_rd(input logic [6:0] op, input logic [1:0] f, input int base, input int st, input int cnt);
    aubt_word_t w;
    ld(1'b0, 3'h0, 64'(base));
    ld(1'b0, 3'h4, 64'(st));
    wbq.delete();
    exec({op, 3'h4, 6'(cnt - 1)}, 16'h0);
    check(72'(wbq.size()), 72'(cnt));
    for (int n = 0; n < cnt; n++)
    begin
      w = pat(base + n);
      if (f == 2'h2) w = {40'h0, w[23:0]};
      chk_wb({f, 6'(st + n), w});
    end
    $display("block read test done");
  endtask
  task automatic t_st(input logic [6:0] op, input logic [1:0] f, input int base, input int st, input int cnt,
                      input int src);
    int         w0;
    aubt_word_t w;
    aubt_word_t m;
    ld(1'b0, 3'h0, 64'(base));
    ld(1'b0, 3'h4, 64'(st));
    w0 = u_aubt_mem_model.wr_cnt;
    exec({op, 3'h4, 6'(cnt - 1)}, 16'h0);
    check(72'(u_aubt_mem_model.wr_cnt - w0), 72'(cnt));
    for (int n = 0; n < cnt; n++)
    begin
      w = pat(src + n);
      m = u_aubt_mem_model.mem[base + n];
      if (f == 2'h2) w = {40'h0, w[23:0]};
      if (f == 2'h2) m = {40'h0, m[23:0]};
      check(72'(m), 72'(w));
    end
    $display("block store test done");
  endtask
  task automatic t_long();
    ld(1'b1, 3'h3, 64'hffffffffffffffff);
    wbq.delete();
    exec({`AUBT_OP_SLONG, 3'h3, 6'h3f}, 16'hffff);
    chk_wb({8'h43, 64'h3fffff});
    exec({`AUBT_OP_SLONG, 3'h6, 6'h15}, 16'h1234);
    chk_wb({8'h46, 64'h151234});
    wbq.delete();
    exec({7'h22, 3'h2, 6'h00}, 16'h0);
    check(72'(wbq.size()), 72'h0);
    $display("long constant test done");
  endtask
  initial
  begin
    {rst_b, inst_valid, ld_en, ld_scalar, err_set} = 5'h0;
    {inst_word, inst_ext, ld_idx, lat, ld_data} = '0;
    irq_chan = 6'h2d;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    t_arith();
    t_chan();
    t_rd(`AUBT_OP_BRD, 2'h2, 16, 50, 20);
    @(posedge mclk);
    lat <= 3'h2;
    t_rd(`AUBT_OP_TRD, 2'h3, 64, 62, 64);
    @(posedge mclk);
    lat <= 3'h5;
    t_st(`AUBT_OP_BST, 2'h2, 160, 50, 20, 16);
    t_st(`AUBT_OP_TST, 2'h3, 200, 62, 3, 64);
    t_long();
    conclude();
  end
endmodule
`default_nettype wire
